/* logic/misp_slave_port.sv */
// two-wire slave port of the monitor: link engine and system side
//
// How it works
// - first byte holds seven address bits then direction, low writes, high reads
// - own address 1000000..1000011 picked by strap wired to ground/supply/data/clock
// - strap level re-sampled at every transaction, never latched once
// - target only: clock, start and stop never driven
// - every byte shifted most significant bit first
// - acknowledge own address, then every byte the master writes
// - first byte after write address loads the register pointer
// - next two written bytes, high first, stored into pointed register
// - address plus pointer only updates pointer, no register written
// - read sends pointed register high byte, then low byte after ack
// - pointer kept across transactions until next pointer byte written
// - master code not acknowledged but switches filtering to high-speed
// - high-speed survives repeated starts, stop returns to fast filtering
// - interface stalled for 28 ms abandons transaction and frees bus
// - with alert pending, ack alert response read and send own address
// - each register is 16 bits moved as two bytes
`timescale 1ns/1ps
`include "misp_params.svh"
module misp_slave_port
  import misp_pkg::*;
#(
  parameter int TIMEOUT_CYC = `MISP_TIMEOUT_CYC,
  parameter logic [1:0] FS_FILT = `MISP_FS_FILT,
  parameter logic [1:0] HS_FILT = `MISP_HS_FILT
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_link,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_address_strap_pin,
  input wire logic i_alert_pending,
  input wire logic [15:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic o_high_speed_mode
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  logic rst_link_n;
  logic [2:0] pin_q;
  logic [2:0] from_sys;
  logic [4:0] to_sys;
  logic [4:0] link_s;
  logic alert_l;
  logic abort_l;
  logic rd_ack_l;
  misp_lines_t filt;
  misp_lines_t filt_d;
  logic [1:0] raw_v;
  logic [1:0] fv;
  logic [1:0] flt_lim;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  misp_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx_shift;
  logic [7:0] tx_next;
  logic [1:0] byte_idx;
  logic sda_drv;
  logic alert_mode;
  logic hs;
  logic s_hi;
  logic s_st;
  logic s_lo;
  logic [6:0] own_addr;
  logic byte_done;
  logic hit_own;
  logic hit_alert;
  logic hit_hs;
  logic [7:0] ptr;
  logic [7:0] wr_hi;
  misp_word_t wr_word;
  logic wr_tgl;
  logic rd_req_tgl;
  logic rd_ack_seen;
  logic [15:0] rd_word;
  logic act_tgl;
  logic act_p;
  logic wr_p;
  logic rd_p;
  logic [15:0] rd_hold;
  logic rd_ack_tgl;
  logic abort;
  logic [TW-1:0] tmo_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // crossings between link and system clocks

  // link reset is released in step with the link clock
  misp_sync #(.W(1), .RST(1'b0)) u_rst_sync (
    .i_clk(i_clk_link),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(rst_link_n)
  );

  // bus lines idle high, so they reset high to avoid a false start
  misp_sync #(.W(3), .RST(3'b011)) u_pin_sync (
    .i_clk(i_clk_link),
    .i_rst_n(rst_link_n),
    .i_d({i_address_strap_pin, i_scl, i_sda}),
    .o_q(pin_q)
  );

  misp_sync #(.W(3), .RST(3'b000)) u_sys2link (
    .i_clk(i_clk_link),
    .i_rst_n(rst_link_n),
    .i_d({i_alert_pending, abort, rd_ack_tgl}),
    .o_q(from_sys)
  );

  assign alert_l = from_sys[2];
  assign abort_l = from_sys[1];
  assign rd_ack_l = from_sys[0];
  assign to_sys = {state != ST_IDLE, act_tgl, hs, wr_tgl, rd_req_tgl};

  misp_sync #(.W(5), .RST(5'b00000)) u_link2sys (
    .i_clk(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_d(to_sys),
    .o_q(link_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // spike filter and bus events on the link clock

  // high-speed needs a short filter, fast mode a longer one
  assign flt_lim = hs ? HS_FILT : FS_FILT;
  assign raw_v = pin_q[1:0];
  assign filt = fv;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_filt
      logic [1:0] cnt;
      logic val;
      assign fv[g] = val;
      always_ff @(posedge i_clk_link or negedge rst_link_n)
      begin
        if (!rst_link_n)
        begin
          cnt <= 2'h0;
          val <= 1'b1;
        end
        else if (raw_v[g] == val)
          cnt <= 2'h0;
        else if (cnt + 2'h1 >= flt_lim)
        begin
          val <= raw_v[g];
          cnt <= 2'h0;
        end
        else
          cnt <= cnt + 2'h1;
      end
    end
  endgenerate

  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
      filt_d <= 2'b11;
    else
      filt_d <= filt;
  end

  // a data edge while the clock stays high is a start or stop
  assign scl_rise = filt.scl & ~filt_d.scl;
  assign scl_fall = ~filt.scl & filt_d.scl;
  assign start = filt.scl & filt_d.scl & filt_d.sda & ~filt.sda;
  assign stop = filt.scl & filt_d.scl & ~filt_d.sda & filt.sda;

  ////////////////////////////////////////////////////////////////////////////
  // address strap and byte decode

  // strap seen idle, at start and with clock low tells its wiring
  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      s_hi <= 1'b0;
      s_st <= 1'b0;
      s_lo <= 1'b0;
    end
    else
    begin
      // raw lines, not filtered ones: a strap following a line leads the filter
      if (raw_v == 2'b11)
        s_hi <= pin_q[2];
      if (start)
        s_st <= pin_q[2];
      if (scl_fall && state == ST_ADDR && bit_cnt == 4'hF)
        s_lo <= pin_q[2];
    end
  end

  always_comb
  begin
    if (!s_hi)
      own_addr = `MISP_ADDR_GND;
    else if (!s_st)
      own_addr = `MISP_ADDR_SDA;
    else if (!s_lo)
      own_addr = `MISP_ADDR_SCL;
    else
      own_addr = `MISP_ADDR_VS;
  end

  // shreg holds the whole byte at the eighth falling clock
  assign byte_done = scl_fall && bit_cnt == 4'h7;
  assign hit_own = shreg[7:1] == own_addr;
  assign hit_alert = shreg[7:1] == `MISP_ADDR_ALERT && shreg[0] && alert_l;
  assign hit_hs = shreg[7:3] == `MISP_HS_CODE;

  // next byte to send: own address on an alert response, else register word high then low, then idle ones
  always_comb
  begin
    tx_next = `MISP_IDLE_BYTE;
    if (byte_idx == 2'h0)
      tx_next = alert_mode ? {own_addr, 1'b0} : rd_word[15:8];
    else if (byte_idx == 2'h1 && !alert_mode)
      tx_next = rd_word[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine: receive on rising clock, drive on falling clock

  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx_shift <= 8'h00;
      byte_idx <= 2'h0;
      sda_drv <= 1'b0;
      alert_mode <= 1'b0;
    end
    else if (abort_l || stop)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      sda_drv <= 1'b0;
    end
    else if (start)
    begin
      state <= ST_ADDR;
      bit_cnt <= 4'hF; // clock fall closing the start wraps this to 0
      sda_drv <= 1'b0;
      byte_idx <= 2'h0;
      alert_mode <= 1'b0;
    end
    else
    begin
      if (scl_rise && bit_cnt != 4'h8)
        shreg <= {shreg[6:0], filt.sda};
      // master nack ends the read; losing arbitration backs off
      if (scl_rise && state == ST_READ)
      begin
        if (bit_cnt == 4'h8 && filt.sda)
          state <= ST_IGNORE;
        else if (bit_cnt != 4'h8 && !sda_drv && !filt.sda)
          state <= ST_IGNORE;
      end
      if (scl_fall)
      begin
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
        case (state)
          ST_ADDR:
          begin
            if (bit_cnt == 4'h7)
            begin
              if (hit_own || hit_alert)
              begin
                sda_drv <= 1'b1;
                alert_mode <= hit_alert && !hit_own;
                state <= shreg[0] ? ST_READ : ST_WRITE;
              end
              else
                state <= ST_IGNORE;
            end
          end
          ST_WRITE:
          begin
            if (bit_cnt == 4'h7)
            begin
              sda_drv <= 1'b1;
              if (byte_idx != 2'h3)
                byte_idx <= byte_idx + 2'h1;
            end
            else
              sda_drv <= 1'b0;
          end
          ST_READ:
          begin
            if (bit_cnt == 4'h8)
            begin
              tx_shift <= tx_next;
              sda_drv <= ~tx_next[7];
              if (byte_idx != 2'h3)
                byte_idx <= byte_idx + 2'h1;
            end
            else if (bit_cnt == 4'h7)
              sda_drv <= 1'b0;
            else
            begin
              tx_shift <= {tx_shift[6:0], 1'b1};
              sda_drv <= ~tx_shift[6];
            end
          end
          default:
            sda_drv <= 1'b0;
        endcase
      end
    end
  end

  // the bus is open drain: only ever pull data low, never the clock
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_drv;

  ////////////////////////////////////////////////////////////////////////////
  // pointer, write word and read request on the link clock

  // a word is handed over only once its low byte is whole
  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      ptr <= 8'h00;
      wr_hi <= 8'h00;
      wr_word <= '0;
      wr_tgl <= 1'b0;
    end
    else if (byte_done && state == ST_WRITE && !start && !stop && !abort_l)
    begin
      case (byte_idx)
        2'h0: ptr <= shreg;
        2'h1: wr_hi <= shreg;
        2'h2:
        begin
          wr_word <= '{ptr: ptr, data: {wr_hi, shreg}};
          wr_tgl <= ~wr_tgl;
        end
        default: wr_hi <= wr_hi;
      endcase
    end
  end

  // read request goes out at the read address, data comes back held
  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      rd_req_tgl <= 1'b0;
      rd_ack_seen <= 1'b0;
      rd_word <= 16'h0000;
    end
    else
    begin
      if (byte_done && state == ST_ADDR && hit_own && shreg[0] && !abort_l)
        rd_req_tgl <= ~rd_req_tgl;
      if (rd_ack_l != rd_ack_seen)
      begin
        rd_ack_seen <= rd_ack_l;
        rd_word <= rd_hold;
      end
    end
  end

  // master code arms high-speed filtering until a stop or a stall abort
  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
      hs <= 1'b0;
    else if (stop || abort_l)
      hs <= 1'b0;
    else if (byte_done && state == ST_ADDR && hit_hs)
      hs <= 1'b1;
  end

  // every clock edge proves the master is alive
  always_ff @(posedge i_clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
      act_tgl <= 1'b0;
    else if (scl_rise || scl_fall || start)
      act_tgl <= ~act_tgl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system side: register strobes, read answer, stall watchdog

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      act_p <= 1'b0;
      wr_p <= 1'b0;
      rd_p <= 1'b0;
    end
    else
    begin
      act_p <= link_s[3];
      wr_p <= link_s[1];
      rd_p <= link_s[0];
    end
  end

  // link-held word and pointer are stable when their toggle arrives
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_reg_addr <= 8'h00;
      o_reg_wdata <= 16'h0000;
    end
    else
    begin
      o_reg_wr <= link_s[1] != wr_p;
      o_reg_rd <= link_s[0] != rd_p;
      if (link_s[1] != wr_p)
      begin
        o_reg_addr <= wr_word.ptr;
        o_reg_wdata <= wr_word.data;
      end
      else if (link_s[0] != rd_p)
        o_reg_addr <= ptr;
    end
  end

  // read data sampled while the read strobe stands
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_hold <= 16'h0000;
      rd_ack_tgl <= 1'b0;
    end
    else if (o_reg_rd)
    begin
      rd_hold <= i_reg_rdata;
      rd_ack_tgl <= ~rd_ack_tgl;
    end
  end

  // abort holds until the link reports idle, so it cannot be missed
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tmo_cnt <= '0;
      abort <= 1'b0;
    end
    else if (!link_s[4])
    begin
      tmo_cnt <= '0;
      abort <= 1'b0;
    end
    else if (link_s[3] != act_p)
      tmo_cnt <= '0;
    else if (tmo_cnt == TW'(TIMEOUT_CYC - 1))
      abort <= 1'b1;
    else
      tmo_cnt <= tmo_cnt + TW'(1);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_high_speed_mode <= 1'b0;
    else
      o_high_speed_mode <= link_s[2];
  end

endmodule

/* pkg/misp_params.svh */
// constants of the monitor two-wire slave port
`ifndef MISP_PARAMS_SVH
`define MISP_PARAMS_SVH
`define MISP_ADDR_GND 7'h40
`define MISP_ADDR_VS 7'h41
`define MISP_ADDR_SDA 7'h42
`define MISP_ADDR_SCL 7'h43
`define MISP_ADDR_ALERT 7'h0C
`define MISP_HS_CODE 5'h01
`define MISP_IDLE_BYTE 8'hFF
`define MISP_TIMEOUT_MS 28
`define MISP_CLK_SYS_KHZ 25000
`define MISP_TIMEOUT_CYC (`MISP_TIMEOUT_MS * `MISP_CLK_SYS_KHZ)
`define MISP_FS_FILT 2'h2
`define MISP_HS_FILT 2'h1
`endif

/* pkg/misp_pkg.sv */
// types shared by the monitor two-wire slave port
package misp_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_IGNORE} misp_state_t;
  typedef struct packed {
    logic [7:0] ptr;
    logic [15:0] data;
  } misp_word_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } misp_lines_t;
endpackage

/* logic/misp_sync.sv */
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module misp_sync
  import misp_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= RST;
      o_q <= RST;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule

/* sim/misp_bus_master.sv */
// behavioural two-wire bus master for the monitor slave port
`timescale 1ns/1ps
module misp_bus_master
(
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // half-bit unit; 1600 ns high, 2000 ns low keep the clock near 280 kHz
  localparam int H = 1600;

  // both lines released at time zero, bus idle high
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  //////////////////////////////////////////
  // start or repeated start; data falls while clock high, clock left low
  task automatic start();
    o_sda = 1'b1;
    #(H/2) o_scl = 1'b1;
    #H o_sda = 1'b0;
    #H o_scl = 1'b0;
    #(H/4);
  endtask

  // stop; data rises while clock high and the line is let go
  task automatic stop();
    o_sda = 1'b0;
    #H o_scl = 1'b1;
    #H o_sda = 1'b1;
    #H;
  endtask

  // n bits from bit 8 down, msb first; data changes only well after clock fall
  task automatic xfer(input logic [8:0] d, input int n, output logic [8:0] q);
    q = 9'h1FF;
    for (int i = 8; i > 8 - n; i--)
    begin
      o_sda = d[i];
      #H o_scl = 1'b1;
      #H q[i] = i_sda;
      o_scl = 1'b0;
      #(H/4);
    end
  endtask
endmodule

/* sim/misp_slave_port_asserts.sv */
// concurrent checks for the monitor two-wire slave port
`timescale 1ns/1ps
module misp_slave_port_asserts
  import misp_pkg::*;
#(
  parameter int TIMEOUT_CYC = 200
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_link,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_reg_wr,
  input wire logic o_reg_rd,
  input wire logic o_high_speed_mode
);
  logic [4:0] since_stop;
  logic prev_sda;

  // link cycles since a stop on the pins; saturates so it never wraps
  always_ff @(posedge i_clk_link or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      since_stop <= 5'h1F;
      prev_sda <= 1'b1;
    end
    else
    begin
      prev_sda <= i_sda;
      if (i_scl && i_sda && !prev_sda)
        since_stop <= 5'h00;
      else if (since_stop != 5'h1F)
        since_stop <= since_stop + 5'h01;
    end
  end

  //////////////////////////////////////////
  // a strobe is high for exactly one cycle
  sequence one_pulse(s);
    s ##1 !s;
  endsequence

  chk_wr_single: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_reg_wr |-> one_pulse(o_reg_wr))
    else $error("write strobe wider than one cycle");
  chk_rd_single: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_reg_rd |-> one_pulse(o_reg_rd))
    else $error("read strobe wider than one cycle");
  chk_strobes_apart: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_reg_wr |-> !o_reg_rd)
    else $error("read and write strobes together");
  chk_sda_open: assert property (
    @(posedge i_clk_link) disable iff (!i_rst_n) o_sda_out == 1'b0)
    else $error("data line driven high");
  chk_oe_clock_low: assert property (
    @(posedge i_clk_link) disable iff (!i_rst_n) $changed(o_sda_oe) |-> !i_scl)
    else $error("data line moved while clock high");
  chk_hs_no_ack: assert property (
    @(posedge i_clk_link) disable iff (!i_rst_n)
    $rose(o_high_speed_mode) |-> !o_sda_oe [*8])
    else $error("master code acknowledged");
  chk_hs_stop_only: assert property (
    @(posedge i_clk_link) disable iff (!i_rst_n)
    $fell(o_high_speed_mode) |-> since_stop < 5'h14)
    else $error("high speed left without stop");
  chk_reset_quiet: assert property (
    @(posedge i_clk_sys) !i_rst_n |-> !o_sda_oe && !o_reg_wr && !o_high_speed_mode)
    else $error("outputs active in reset");
endmodule

bind misp_slave_port misp_slave_port_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_asserts (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_link(i_clk_link),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd), .o_high_speed_mode(o_high_speed_mode));

/* sim/misp_slave_port_tb_top.sv */
// self-checking bench of the monitor two-wire slave port
`timescale 1ns/1ps
module misp_slave_port_tb_top import misp_pkg::*;;
  localparam int TO = 200;
  logic clk_sys, clk_link, rst_n, alert, m_scl, m_sda, sda, oe, sda_out, strap;
  logic wr, rd, hs;
  logic [1:0] sel;
  logic [7:0] addr, salt;
  logic [15:0] wdata, rdata;
  int mismatches, num_checks, wr_cnt, rd_cnt;
  misp_word_t last_wr;

  function automatic logic [6:0] own(input logic [1:0] s);
    return {5'h10, s};
  endfunction
  function automatic logic [15:0] word_at(input logic [7:0] p);
    return {p ^ salt, ~p};
  endfunction

  // open-drain data line with pull-up; strap wiring picked by sel
  assign sda = m_sda & ~oe;
  assign strap = (sel == 2'h2) ? sda : (sel == 2'h3) ? m_scl : sel[0];
  // written out so that a change of salt is seen as well as a change of address
  assign rdata = {addr ^ salt, ~addr};

  // unrelated clocks, link slower by design
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 1'b0;
    #37;
    forever #80 clk_link = ~clk_link;
  end

  // register bank side: count every read and write strobe, keep the last write
  always @(posedge clk_sys)
  begin
    if (wr === 1'b1)
    begin
      wr_cnt++;
      last_wr <= {addr, wdata};
    end
    if (rd === 1'b1)
      rd_cnt++;
  end

  misp_slave_port #(.TIMEOUT_CYC(TO)) u_misp_slave_port (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_link(clk_link), .i_scl(m_scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe), .i_address_strap_pin(strap),
    .i_alert_pending(alert), .i_reg_rdata(rdata), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd), .o_high_speed_mode(hs));
  misp_bus_master u_misp_bus_master (.i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));

  //////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // address then n bytes; acknowledges expected only for our own address
  task automatic wr_seq(input logic [6:0] dev, input logic [23:0] b, input int n);
    logic [8:0] q;
    u_misp_bus_master.start();
    u_misp_bus_master.xfer({dev, 1'b0, 1'b1}, 9, q);
    check(q[0], dev !== own(sel));
    for (int i = 0; i < n; i++)
    begin
      u_misp_bus_master.xfer({b[23-8*i -: 8], 1'b1}, 9, q);
      check(q[0], dev !== own(sel));
    end
  endtask
  // read of n bytes, the last one not acknowledged by the master
  task automatic rd_seq(input logic [6:0] dev, input logic a, input int n,
                        output logic [23:0] r);
    logic [8:0] q;
    u_misp_bus_master.start();
    u_misp_bus_master.xfer({dev, 1'b1, 1'b1}, 9, q);
    check(q[0], a);
    for (int i = 0; i < n; i++)
    begin
      u_misp_bus_master.xfer({8'hFF, i == n - 1}, 9, q);
      r[23-8*i -: 8] = q[8:1];
    end
  endtask
  // bounded wait on the high-speed flag
  task automatic wait_hs(input logic v);
    int n;
    n = 0;
    while (hs !== v && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    check(hs, v);
    if (n == 400)
      results();
  endtask

  //////////////////////////////////////////
  initial
  begin
    logic [23:0] r;
    logic [8:0] q;
    logic [7:0] p;
    int n0;
    alert = 1'b0;
    sel = 2'h0;
    salt = 8'h00;
    void'($urandom(32'h721C5EB3));
    // a real falling edge once every process waits, so no flop misses reset
    #1 rst_n = 1'b0;
    repeat (4) @(posedge clk_link);
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    salt = 8'($urandom);
    repeat (12) @(posedge clk_link);
    // each strap wiring: own write, foreign write, read back
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys);
      #1 sel = 2'(s);
      p = (s == 0) ? 8'h00 : (s == 3) ? 8'hFF : 8'($urandom);
      r = {p, 16'($urandom)};
      n0 = wr_cnt;
      wr_seq(own(sel), r, 3);
      u_misp_bus_master.stop();
      check(wr_cnt, n0 + 1);
      check(last_wr, r);
      wr_seq(own(sel + 2'h1), {~p, 16'($urandom)}, 3);
      u_misp_bus_master.stop();
      check(wr_cnt, n0 + 1);
      rd_seq(own(sel), 1'b0, 2, r);
      u_misp_bus_master.stop();
      check(r[23:8], word_at(p));
    end
    $display("test strap decode done");
    // pointer only, repeated start, read with low byte acknowledged
    p = 8'($urandom);
    n0 = wr_cnt;
    wr_seq(own(sel), {p, 16'h0000}, 1);
    rd_seq(own(sel), 1'b0, 3, r);
    u_misp_bus_master.stop();
    check(wr_cnt, n0);
    check(r, {word_at(p), 8'hFF});
    rd_seq(own(sel), 1'b0, 2, r);
    u_misp_bus_master.stop();
    check(r[23:8], word_at(p));
    // word cut short by a stop is dropped
    wr_seq(own(sel), {~p, 16'($urandom)}, 2);
    u_misp_bus_master.stop();
    check(wr_cnt, n0);
    $display("test pointer read done");
    // high-speed entry, kept over repeated start, left on stop
    u_misp_bus_master.start();
    u_misp_bus_master.xfer({5'h01, 3'($urandom), 1'b1}, 9, q);
    check(q[0], 1'b1);
    wait_hs(1'b1);
    r = {8'($urandom), 16'($urandom)};
    wr_seq(own(sel), r, 3);
    check(hs, 1'b1);
    u_misp_bus_master.stop();
    check(last_wr, r);
    wait_hs(1'b0);
    $display("test high speed done");
    // alert response with and without a pending alert
    @(posedge clk_sys);
    #1 alert = 1'b1;
    n0 = rd_cnt;
    rd_seq(7'h0C, 1'b0, 2, r);
    u_misp_bus_master.stop();
    check(r[23:8], {own(sel), 1'b0, 8'hFF});
    check(rd_cnt, n0);
    @(posedge clk_sys);
    #1 alert = 1'b0;
    rd_seq(7'h0C, 1'b1, 0, r);
    u_misp_bus_master.stop();
    $display("test alert done");
    // clock held low during the acknowledge until the bus is given up
    u_misp_bus_master.start();
    u_misp_bus_master.xfer({own(sel), 1'b0, 1'b1}, 8, q);
    #2000;
    check(oe, 1'b1);
    repeat (TO + 100) @(posedge clk_sys);
    check(oe, 1'b0);
    u_misp_bus_master.stop();
    $display("test stall done");
    results();
  end
endmodule
